// file: src/wcsc_regs.svh
/*
 * Timing and encoding constants for the charger state controller.
 * Assumes a 100 MHz clock; included by bare name.
 */
`ifndef WCSC_REGS_SVH
`define WCSC_REGS_SVH

// Blink timing: half period of one blink phase, in microseconds
`define WCSC_BLINK_HALF_US 32'd10
`define WCSC_CLK_MHZ 32'd100
`define WCSC_BLINK_HALF_CYC (`WCSC_BLINK_HALF_US * `WCSC_CLK_MHZ)
// Number of on/off phases in the power-on blink sequence
`define WCSC_BLINK_PHASES 4'h6
// Digital ping attempt length, in microseconds
`define WCSC_DPING_US 32'd50
`define WCSC_DPING_CYC (`WCSC_DPING_US * `WCSC_CLK_MHZ)
`define WCSC_CNT_W 16

`endif

// file: src/wcsc_pkg.sv
/*
 * Types shared by the charger state controller.
 * Assumes nothing of its surroundings.
 */
package wcsc_pkg;
    // Gray-coded along power-on, wait, ping, id, transfer
    typedef enum logic [2:0] {
        WCSC_OFF = 3'h0,
        WCSC_POWER_ON = 3'h1,
        WCSC_WAIT_ANALOG = 3'h3,
        WCSC_WAIT_DIGITAL = 3'h2,
        WCSC_ID_CONFIG = 3'h6,
        WCSC_TRANSFER = 3'h7,
        WCSC_CHARGED = 3'h5,
        WCSC_FAULT = 3'h4
    } wcsc_state_type;
endpackage

// file: src/wcsc_blinker.sv
/*
 * Power-on blink sequencer: counts a fixed number of timed phases.
 * Assumes a single 100 MHz clock and a start pulse from the controller.
 */
`include "wcsc_regs.svh"

module wcsc_blinker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    output logic busy_o,
    output logic phase_on_o,
    output logic done_o
);
    logic [`WCSC_CNT_W-1:0] tick;
    logic [3:0] phase;

    // ----------------------------------------
    // Phase timer
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tick <= '0;
            phase <= 4'h0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (abort_i) begin
                busy_o <= 1'b0;
                tick <= '0;
            end else if (start_i) begin
                busy_o <= 1'b1;
                tick <= '0;
                phase <= 4'h0;
            end else if (busy_o) begin
                if (tick == `WCSC_CNT_W'(`WCSC_BLINK_HALF_CYC - 1)) begin
                    tick <= '0;
                    if (phase == `WCSC_BLINK_PHASES - 4'h1) begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                    end
                    phase <= phase + 4'h1;
                end else begin
                    tick <= tick + `WCSC_CNT_W'(1);
                end
            end
        end
    end

    // Even phases light the indicators
    assign phase_on_o = busy_o & ~phase[0];
endmodule

// file: src/wcsc_control.sv
/*
 * Operating-state controller of an inductive power transmitter.
 * Assumes all inputs synchronous to clk_i; detection, packet decoding
 * and temperature sensing are done elsewhere and arrive as levels/pulses.
 */
// Contract
// - The sequence runs only while supply is present and standby is low, else idle.
// - Entering power-on plays a blink sequence before becoming operational.
// - The wait state looks for a receiver with a low-power analog ping.
// - The wait state also offers a digital ping run by the signal processor.
// - In identification and configuration, messages are exchanged and power starts.
// - After detection and recognition, power transfer runs while charging.
// - A charge-complete message moves the controller to the charged state.
// - A receiver error report forces the fault state.
// - Receiver or transmitter overtemperature forces the fault state.
// - Two indicator outputs show charging (green) or fault (red).
// - There is no foreign object check state or transition.
`include "wcsc_regs.svh"

module wcsc_control (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic supply_ok_i,
    input wire logic standby_pin_i,
    input wire logic analog_detect_i,
    input wire logic digital_detect_i,
    input wire logic digital_ping_en_i,
    input wire logic id_config_ok_i,
    input wire logic charge_complete_i,
    input wire logic receiver_error_i,
    input wire logic rx_overtemp_i,
    input wire logic tx_overtemp_i,
    input wire logic receiver_lost_i,
    output logic analog_ping_en_o,
    output logic digital_ping_o,
    output logic comm_en_o,
    output logic power_en_o,
    output logic green_indicator_o,
    output logic red_indicator_o,
    output logic [2:0] state_o
);
    wcsc_pkg::wcsc_state_type state, next_state;
    logic active;
    logic blink_start, blink_busy, blink_on, blink_done;
    logic [`WCSC_CNT_W-1:0] ping_cnt;
    logic fault_cond;

    function automatic logic is_after_detect(input wcsc_pkg::wcsc_state_type s);
        is_after_detect = (s == wcsc_pkg::WCSC_ID_CONFIG) ||
                          (s == wcsc_pkg::WCSC_TRANSFER) ||
                          (s == wcsc_pkg::WCSC_CHARGED);
    endfunction

    assign active = supply_ok_i & ~standby_pin_i;
    assign fault_cond = receiver_error_i | rx_overtemp_i | tx_overtemp_i;

    // ----------------------------------------
    // Power-on blink sequence
    // ----------------------------------------
    assign blink_start = active && (state == wcsc_pkg::WCSC_OFF);

    wcsc_blinker u_blinker (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(blink_start),
        .abort_i(~active),
        .busy_o(blink_busy),
        .phase_on_o(blink_on),
        .done_o(blink_done)
    );

    // ----------------------------------------
    // Next state; no foreign object check path exists
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            wcsc_pkg::WCSC_OFF: begin
                if (active) next_state = wcsc_pkg::WCSC_POWER_ON;
            end
            wcsc_pkg::WCSC_POWER_ON: begin
                if (blink_done) next_state = wcsc_pkg::WCSC_WAIT_ANALOG;
            end
            wcsc_pkg::WCSC_WAIT_ANALOG: begin
                if (analog_detect_i) next_state = wcsc_pkg::WCSC_ID_CONFIG;
                else if (digital_ping_en_i) next_state = wcsc_pkg::WCSC_WAIT_DIGITAL;
            end
            wcsc_pkg::WCSC_WAIT_DIGITAL: begin
                if (digital_detect_i) next_state = wcsc_pkg::WCSC_ID_CONFIG;
                else if (ping_cnt == `WCSC_CNT_W'(`WCSC_DPING_CYC - 1))
                    next_state = wcsc_pkg::WCSC_WAIT_ANALOG;
            end
            wcsc_pkg::WCSC_ID_CONFIG: begin
                if (id_config_ok_i) next_state = wcsc_pkg::WCSC_TRANSFER;
            end
            wcsc_pkg::WCSC_TRANSFER: begin
                if (charge_complete_i) next_state = wcsc_pkg::WCSC_CHARGED;
            end
            wcsc_pkg::WCSC_CHARGED: begin
                next_state = wcsc_pkg::WCSC_CHARGED;
            end
            wcsc_pkg::WCSC_FAULT: begin
                // Held until the receiver goes away with no fault cause left, or power cycles
                next_state = wcsc_pkg::WCSC_FAULT;
            end
            default: next_state = wcsc_pkg::WCSC_OFF;
        endcase
        // Fault outranks removal so a hot receiver cannot re-ping at once
        if (state != wcsc_pkg::WCSC_OFF && state != wcsc_pkg::WCSC_POWER_ON) begin
            if (is_after_detect(state) && receiver_lost_i)
                next_state = wcsc_pkg::WCSC_WAIT_ANALOG;
            if (state == wcsc_pkg::WCSC_FAULT && receiver_lost_i && !fault_cond)
                next_state = wcsc_pkg::WCSC_WAIT_ANALOG;
            if (fault_cond) next_state = wcsc_pkg::WCSC_FAULT;
        end
        if (!active) next_state = wcsc_pkg::WCSC_OFF;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) state <= wcsc_pkg::WCSC_OFF;
        else state <= next_state;
    end

    // ----------------------------------------
    // Digital ping window timer
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ping_cnt <= '0;
        end else if (state == wcsc_pkg::WCSC_WAIT_DIGITAL) begin
            ping_cnt <= ping_cnt + `WCSC_CNT_W'(1);
        end else begin
            ping_cnt <= '0;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_ping_en_o <= 1'b0;
            digital_ping_o <= 1'b0;
            comm_en_o <= 1'b0;
            power_en_o <= 1'b0;
            state_o <= 3'h0;
        end else begin
            analog_ping_en_o <= (next_state == wcsc_pkg::WCSC_WAIT_ANALOG);
            digital_ping_o <= (next_state == wcsc_pkg::WCSC_WAIT_DIGITAL);
            comm_en_o <= (next_state == wcsc_pkg::WCSC_ID_CONFIG) ||
                         (next_state == wcsc_pkg::WCSC_TRANSFER);
            power_en_o <= (next_state == wcsc_pkg::WCSC_ID_CONFIG) ||
                          (next_state == wcsc_pkg::WCSC_TRANSFER);
            state_o <= next_state;
        end
    end

    // Green: charging; red: fault; both during blink; green solid when charged
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            green_indicator_o <= 1'b0;
            red_indicator_o <= 1'b0;
        end else begin
            case (next_state)
                wcsc_pkg::WCSC_POWER_ON: begin
                    green_indicator_o <= blink_on;
                    red_indicator_o <= blink_on;
                end
                wcsc_pkg::WCSC_TRANSFER, wcsc_pkg::WCSC_ID_CONFIG,
                wcsc_pkg::WCSC_CHARGED: begin
                    green_indicator_o <= 1'b1;
                    red_indicator_o <= 1'b0;
                end
                wcsc_pkg::WCSC_FAULT: begin
                    green_indicator_o <= 1'b0;
                    red_indicator_o <= 1'b1;
                end
                default: begin
                    green_indicator_o <= 1'b0;
                    red_indicator_o <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_inactive_off;
        @(posedge clk_i) disable iff (rst_i)
        !active |=> state == wcsc_pkg::WCSC_OFF && !power_en_o;
    endproperty
    a_inactive_off: assert property (p_inactive_off) else $error("inactive not off");

    property p_blink_first;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_POWER_ON && active && !blink_done |=>
            state == wcsc_pkg::WCSC_POWER_ON || state == wcsc_pkg::WCSC_OFF;
    endproperty
    a_blink_first: assert property (p_blink_first) else $error("left power-on early");

    property p_analog_ping;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_WAIT_ANALOG |-> analog_ping_en_o;
    endproperty
    a_analog_ping: assert property (p_analog_ping) else $error("analog ping off");

    // Run length of the digital ping output; a window that overstays its
    // timer would otherwise only show up as a hang
    logic [`WCSC_CNT_W-1:0] dping_run;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dping_run <= '0;
        end else if (digital_ping_o) begin
            dping_run <= dping_run + `WCSC_CNT_W'(1);
        end else begin
            dping_run <= '0;
        end
    end

    property p_digital_timeout;
        @(posedge clk_i) disable iff (rst_i)
        dping_run <= `WCSC_CNT_W'(`WCSC_DPING_CYC);
    endproperty
    a_digital_timeout: assert property (p_digital_timeout) else $error("ping stuck");

    property p_power_id;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_ID_CONFIG |-> power_en_o && comm_en_o;
    endproperty
    a_power_id: assert property (p_power_id) else $error("no power in id state");

    property p_transfer;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_ID_CONFIG && id_config_ok_i && active && !fault_cond
            && !receiver_lost_i |=> state == wcsc_pkg::WCSC_TRANSFER && power_en_o;
    endproperty
    a_transfer: assert property (p_transfer) else $error("transfer not started");

    property p_charged;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_TRANSFER && charge_complete_i && active && !fault_cond
            && !receiver_lost_i |=> state == wcsc_pkg::WCSC_CHARGED && !power_en_o;
    endproperty
    a_charged: assert property (p_charged) else $error("charged not entered");

    property p_fault;
        @(posedge clk_i) disable iff (rst_i)
        fault_cond && active && state != wcsc_pkg::WCSC_OFF
            && state != wcsc_pkg::WCSC_POWER_ON |=> state == wcsc_pkg::WCSC_FAULT ##0 red_indicator_o;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not entered");

    property p_lost;
        @(posedge clk_i) disable iff (rst_i)
        is_after_detect(state) && receiver_lost_i && active && !fault_cond |=>
            state == wcsc_pkg::WCSC_WAIT_ANALOG && !power_en_o;
    endproperty
    a_lost: assert property (p_lost) else $error("power not stopped on loss");

    property p_green;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_TRANSFER |-> green_indicator_o && !red_indicator_o;
    endproperty
    a_green: assert property (p_green) else $error("green off while charging");

    property p_wait_dark;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_WAIT_ANALOG || state == wcsc_pkg::WCSC_WAIT_DIGITAL |->
            !power_en_o && !comm_en_o && !green_indicator_o && !red_indicator_o;
    endproperty
    a_wait_dark: assert property (p_wait_dark) else $error("power in wait");

    property p_blink_pair;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_POWER_ON |->
            green_indicator_o == red_indicator_o && !power_en_o;
    endproperty
    a_blink_pair: assert property (p_blink_pair) else $error("blink pair split");

    property p_analog_find;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_WAIT_ANALOG && analog_detect_i && active && !fault_cond |=>
            state == wcsc_pkg::WCSC_ID_CONFIG;
    endproperty
    a_analog_find: assert property (p_analog_find) else $error("detect ignored");

    property p_digital_find;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_WAIT_DIGITAL && digital_detect_i && active && !fault_cond |=>
            state == wcsc_pkg::WCSC_ID_CONFIG;
    endproperty
    a_digital_find: assert property (p_digital_find) else $error("detect ignored");

    property p_off_dark;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_OFF |->
            !green_indicator_o && !red_indicator_o && !power_en_o;
    endproperty
    a_off_dark: assert property (p_off_dark) else $error("lit in standby");

    property p_fault_hold;
        @(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_FAULT && fault_cond && active |=>
            state == wcsc_pkg::WCSC_FAULT;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault left");

    c_blink_done: cover property (@(posedge clk_i) disable iff (rst_i) blink_done);
    c_charged: cover property (@(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_CHARGED);
    c_fault: cover property (@(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_FAULT);
    c_digital: cover property (@(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_WAIT_DIGITAL ##1 state == wcsc_pkg::WCSC_ID_CONFIG);
    c_lost: cover property (@(posedge clk_i) disable iff (rst_i)
        state == wcsc_pkg::WCSC_CHARGED ##1 state == wcsc_pkg::WCSC_WAIT_ANALOG);
endmodule

// file: verification/wcsc_receiver_model.sv
/*
 * Behavioural power receiver that sits on the transmitter coil.
 * Assumes the bench places, fills and faults it; the ID delay sets
 * whether it answers promptly or slowly.
 */
module wcsc_receiver_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic present_i,
    input wire logic full_i,
    input wire logic err_i,
    input wire logic [7:0] id_delay_i,
    input wire logic analog_ping_en_i,
    input wire logic digital_ping_i,
    input wire logic comm_en_i,
    input wire logic power_en_i,
    output logic analog_detect_o,
    output logic digital_detect_o,
    output logic id_config_ok_o,
    output logic charge_complete_o,
    output logic receiver_error_o,
    output logic receiver_lost_o
);
    logic engaged;
    logic [7:0] id_cnt;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            analog_detect_o <= 1'b0;
            digital_detect_o <= 1'b0;
            id_config_ok_o <= 1'b0;
            charge_complete_o <= 1'b0;
            receiver_error_o <= 1'b0;
            receiver_lost_o <= 1'b0;
            engaged <= 1'b0;
            id_cnt <= 8'h00;
        end else begin
            analog_detect_o <= present_i && analog_ping_en_i;
            digital_detect_o <= present_i && digital_ping_i;
            id_config_ok_o <= comm_en_i && present_i && id_cnt == id_delay_i;
            charge_complete_o <= full_i && power_en_i;
            receiver_error_o <= err_i && (comm_en_i || power_en_i);
            receiver_lost_o <= engaged && !present_i;
            // Loss only means something once the coil has talked to us
            if (analog_ping_en_i || digital_ping_i) begin
                engaged <= 1'b0;
            end else if (comm_en_i) begin
                engaged <= 1'b1;
            end
            if (!comm_en_i) begin
                id_cnt <= 8'h00;
            end else if (id_cnt != 8'hFF) begin
                id_cnt <= id_cnt + 8'h01;
            end
        end
    end
endmodule

// file: verification/test_wireless_charger_state_control.sv
/*
 * Self-checking bench for the charger state controller.
 * Assumes the receiver model beside it and a 100 MHz clock.
 */
module test_wireless_charger_state_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, supply_ok_i = 1'b0, standby_pin_i = 1'b1;
    logic digital_ping_en_i = 1'b0, tx_overtemp_i = 1'b0, rx_overtemp_i = 1'b0;
    logic present = 1'b0, full = 1'b0, err = 1'b0;
    logic [7:0] id_delay = 8'h03;
    logic a_det, d_det, id_ok, c_done, r_err, r_lost;
    logic a_png, d_png, comm, pwr, grn, red;
    logic [2:0] state_o;
    int err_total = 0, check_count = 0, n, k, rises, rot;

    wcsc_control i_wcsc_control (.clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok_i),
        .standby_pin_i(standby_pin_i), .analog_detect_i(a_det), .digital_detect_i(d_det),
        .digital_ping_en_i(digital_ping_en_i), .id_config_ok_i(id_ok),
        .charge_complete_i(c_done), .receiver_error_i(r_err), .rx_overtemp_i(rx_overtemp_i),
        .tx_overtemp_i(tx_overtemp_i), .receiver_lost_i(r_lost), .analog_ping_en_o(a_png),
        .digital_ping_o(d_png), .comm_en_o(comm), .power_en_o(pwr),
        .green_indicator_o(grn), .red_indicator_o(red), .state_o(state_o));
    wcsc_receiver_model i_wcsc_receiver_model (.clk_i(clk_i), .rst_i(rst_i),
        .present_i(present), .full_i(full), .err_i(err), .id_delay_i(id_delay),
        .analog_ping_en_i(a_png), .digital_ping_i(d_png), .comm_en_i(comm), .power_en_i(pwr),
        .analog_detect_o(a_det), .digital_detect_o(d_det), .id_config_ok_o(id_ok),
        .charge_complete_o(c_done), .receiver_error_o(r_err), .receiver_lost_o(r_lost));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Expectations and checks
    // ----------------------------------------
    function automatic logic [4:0] exp_out(input logic [2:0] s);
        case (s)
            wcsc_pkg::WCSC_WAIT_ANALOG: exp_out = 5'h10;
            wcsc_pkg::WCSC_WAIT_DIGITAL: exp_out = 5'h08;
            wcsc_pkg::WCSC_ID_CONFIG, wcsc_pkg::WCSC_TRANSFER: exp_out = 5'h06;
            wcsc_pkg::WCSC_CHARGED: exp_out = 5'h02;
            wcsc_pkg::WCSC_FAULT: exp_out = 5'h01;
            default: exp_out = 5'h00;
        endcase
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_state(input logic [2:0] s);
        chk({5'h00, state_o}, {5'h00, s});
        chk({3'h0, a_png, d_png, pwr, grn, red}, {3'h0, exp_out(s)});
        chk({7'h00, comm}, {7'h00, s == wcsc_pkg::WCSC_ID_CONFIG ||
            s == wcsc_pkg::WCSC_TRANSFER});
    endtask

    task automatic wait_state(input logic [2:0] s, input int lim);
        n = 0;
        while (state_o !== s && n < lim) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk_state(s);
    endtask

    task automatic power_up();
        @(posedge clk_i);
        supply_ok_i <= 1'b1;
        standby_pin_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_state(wcsc_pkg::WCSC_POWER_ON);
        n = 0;
        rises = 0;
        while (state_o === wcsc_pkg::WCSC_POWER_ON && n < 7000) begin
            k = grn;
            @(posedge clk_i);
            #1;
            n++;
            if (grn === 1'b1 && k == 0) rises++;
        end
        chk(8'(rises), 8'h03);
        chk({7'h00, n >= 5995 && n <= 6005}, 8'h01);
        chk_state(wcsc_pkg::WCSC_WAIT_ANALOG);
    endtask

    task automatic reach_transfer();
        @(posedge clk_i);
        present <= 1'b1;
        wait_state(wcsc_pkg::WCSC_ID_CONFIG, 10);
        chk({6'h00, comm, pwr}, 8'h03);
        wait_state(wcsc_pkg::WCSC_TRANSFER, 300);
        repeat ($urandom_range(1, 40)) @(posedge clk_i);
        #1;
        chk_state(wcsc_pkg::WCSC_TRANSFER);
    endtask

    task automatic lose_receiver(input int lim);
        @(posedge clk_i);
        present <= 1'b0;
        wait_state(wcsc_pkg::WCSC_WAIT_ANALOG, lim);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        k = $urandom(32'ha4f7);
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({1'b0, a_png, d_png, comm, pwr, state_o}, 8'h00);
        power_up();
        $display("test power-on finished");
        for (int i = 0; i < 2; i++) begin
            id_delay <= (i == 0) ? 8'h00 : 8'($urandom_range(1, 200));
            reach_transfer();
            @(posedge clk_i);
            full <= 1'b1;
            wait_state(wcsc_pkg::WCSC_CHARGED, 4);
            full <= 1'b0;
            lose_receiver(5);
        end
        $display("test charge cycle finished");
        @(posedge clk_i);
        digital_ping_en_i <= 1'b1;
        @(posedge clk_i);
        digital_ping_en_i <= 1'b0;
        #1;
        chk_state(wcsc_pkg::WCSC_WAIT_DIGITAL);
        wait_state(wcsc_pkg::WCSC_WAIT_ANALOG, 5100);
        chk({7'h00, n >= 4995 && n <= 5005}, 8'h01);
        @(posedge clk_i);
        digital_ping_en_i <= 1'b1;
        @(posedge clk_i);
        digital_ping_en_i <= 1'b0;
        present <= 1'b1;
        wait_state(wcsc_pkg::WCSC_ID_CONFIG, 10);
        lose_receiver(5);
        $display("test digital ping finished");
        // One random rotation so every fault cause is hit exactly once
        rot = $urandom_range(0, 2);
        for (int i = 0; i < 3; i++) begin
            k = (i + rot) % 3;
            reach_transfer();
            @(posedge clk_i);
            if (k == 0) tx_overtemp_i <= 1'b1;
            if (k == 1) rx_overtemp_i <= 1'b1;
            if (k == 2) err <= 1'b1;
            wait_state(wcsc_pkg::WCSC_FAULT, (k == 2) ? 3 : 1);
            present <= 1'b0;
            repeat (5) @(posedge clk_i);
            #1;
            if (k != 2) chk_state(wcsc_pkg::WCSC_FAULT);
            tx_overtemp_i <= 1'b0;
            rx_overtemp_i <= 1'b0;
            err <= 1'b0;
            wait_state(wcsc_pkg::WCSC_WAIT_ANALOG, 5);
        end
        $display("test faults finished");
        reach_transfer();
        @(posedge clk_i);
        standby_pin_i <= 1'b1;
        tx_overtemp_i <= 1'b1;
        @(posedge clk_i);
        #1;
        chk_state(wcsc_pkg::WCSC_OFF);
        tx_overtemp_i <= 1'b0;
        power_up();
        reach_transfer();
        @(posedge clk_i);
        supply_ok_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk_state(wcsc_pkg::WCSC_OFF);
        $display("test inactive finished");
        test_done();
    end

    initial begin
        #600000;
        err_total++;
        test_done();
    end
endmodule
